// ### hdl/cfgdec_consts.svh
`ifndef CFGDEC_CONSTS_SVH
`define CFGDEC_CONSTS_SVH

// register byte offsets on the bus
`define CFGDEC_OFS_IDENT     12'h000
`define CFGDEC_OFS_SECURITY  12'h004
`define CFGDEC_OFS_OSCSEL    12'h008
`define CFGDEC_OFS_OSC       12'h00C
`define CFGDEC_OFS_WDT       12'h010
`define CFGDEC_OFS_POR       12'h014
`define CFGDEC_OFS_DEBUG     12'h018
`define CFGDEC_OFS_DECODED   12'h01C
`define CFGDEC_OFS_STATUS    12'h020

// configuration word field positions (16-bit words)
`define CFGDEC_RDGUARD_BIT   1
`define CFGDEC_WRGUARD_BIT   0
`define CFGDEC_TWOSPD_BIT    7
`define CFGDEC_PWMLK_BIT     6
`define CFGDEC_CLKSEL_LSB    0
`define CFGDEC_SWMODE_LSB    6
`define CFGDEC_IOL1_BIT      5
`define CFGDEC_OSCIO_BIT     2
`define CFGDEC_PMODE_LSB     0
`define CFGDEC_WDFORCE_BIT   7
`define CFGDEC_WINOFF_BIT    6
`define CFGDEC_WDPRE_BIT     4
`define CFGDEC_WDPOST_LSB    0
`define CFGDEC_WDWIN_LSB     6
`define CFGDEC_I2C2_BIT      5
`define CFGDEC_I2C1_BIT      4
`define CFGDEC_SCAN_BIT      5
`define CFGDEC_DBGCH_LSB     0

// implemented bit masks per configuration word
`define CFGDEC_MASK_SEC      16'h0003
`define CFGDEC_MASK_OSCSEL   16'h00C7
`define CFGDEC_MASK_OSC      16'h00E7
`define CFGDEC_MASK_WDT      16'h00DF
`define CFGDEC_MASK_POR      16'h00F0
`define CFGDEC_MASK_DEBUG    16'h0023

// load sequencing: two cycles per word read (one wait cycle)
`define CFGDEC_NUM_WORDS     3'd6
`define CFGDEC_RD_LATENCY    2'd1

`endif

// ### hdl/cfgdec_pkg.sv
package cfgdec_pkg;

  typedef enum logic [2:0] {
    CFGDEC_SRC_FAST     = 3'b000,
    CFGDEC_SRC_FASTPLL  = 3'b001,
    CFGDEC_SRC_PRI      = 3'b010,
    CFGDEC_SRC_PRIPLL   = 3'b011,
    CFGDEC_SRC_RSVD4    = 3'b100,
    CFGDEC_SRC_SLOW     = 3'b101,
    CFGDEC_SRC_RSVD6    = 3'b110,
    CFGDEC_SRC_FASTDIV  = 3'b111
  } cfgdec_clk_src_t;

  typedef enum logic [1:0] {
    CFGDEC_POSC_EXT     = 2'b00,
    CFGDEC_POSC_XT      = 2'b01,
    CFGDEC_POSC_HS      = 2'b10,
    CFGDEC_POSC_OFF     = 2'b11
  } cfgdec_posc_t;

  typedef enum logic [1:0] {
    CFGDEC_LD_IDLE      = 2'b00,
    CFGDEC_LD_READ      = 2'b01,
    CFGDEC_LD_DONE      = 2'b10
  } cfgdec_load_st_t;

endpackage

// ### hdl/cfgdec_nv_reader.sv
`timescale 1ns/10ps
`include "cfgdec_consts.svh"

// steps through the configuration words once, one word per request
module cfgdec_nv_reader (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // control
  input  wire logic        start_i,
  // storage port
  output logic [2:0]       nv_addr_o,
  output logic             nv_rd_o,
  input  wire logic [15:0] nv_data_i,
  // word out
  output logic             word_vld_o,
  output logic [2:0]       word_idx_o,
  output logic [15:0]      word_o,
  output logic             done_o
);

  cfgdec_pkg::cfgdec_load_st_t st_q;
  logic [1:0]                  wait_q;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q       <= cfgdec_pkg::CFGDEC_LD_IDLE;
      nv_addr_o  <= 3'h0;
      nv_rd_o    <= 1'b0;
      wait_q     <= 2'h0;
      word_vld_o <= 1'b0;
      word_idx_o <= 3'h0;
      word_o     <= 16'h0000;
      done_o     <= 1'b0;
    end else begin
      word_vld_o <= 1'b0;
      unique case (st_q)
        cfgdec_pkg::CFGDEC_LD_IDLE: begin
          if (start_i) begin
            st_q      <= cfgdec_pkg::CFGDEC_LD_READ;
            nv_addr_o <= 3'h0;
            nv_rd_o   <= 1'b1;
            wait_q    <= `CFGDEC_RD_LATENCY;
          end
        end
        cfgdec_pkg::CFGDEC_LD_READ: begin
          if (wait_q != 2'h0) begin
            nv_rd_o <= 1'b0;
            wait_q  <= wait_q - 2'h1;
          end else begin
            word_vld_o <= 1'b1;
            word_idx_o <= nv_addr_o;
            word_o     <= nv_data_i;
            if (nv_addr_o == `CFGDEC_NUM_WORDS - 3'd1) begin
              st_q   <= cfgdec_pkg::CFGDEC_LD_DONE;
              done_o <= 1'b1;
            end else begin
              nv_addr_o <= nv_addr_o + 3'h1;
              nv_rd_o   <= 1'b1;
              wait_q    <= `CFGDEC_RD_LATENCY;
            end
          end
        end
        cfgdec_pkg::CFGDEC_LD_DONE: begin
          done_o <= 1'b1;
        end
        default: begin
          st_q <= cfgdec_pkg::CFGDEC_LD_IDLE;
        end
      endcase
    end
  end

endmodule // cfgdec_nv_reader

// ### hdl/cfgdec_top.sv
`timescale 1ns/10ps
`include "cfgdec_consts.svh"

module cfgdec_top #(
  // arbitrary neutral identification value
  parameter logic [23:0] DEVICE_ID = 24'h00A5A5
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // nonvolatile storage
  output logic [2:0]       nv_addr_o,
  output logic             nv_rd_o,
  input  wire logic [15:0] nv_data_i,
  // software watchdog control
  input  wire logic        watchdog_soft_on_i,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // decoded settings
  output logic             cfg_valid_o,
  output logic             program_read_block_o,
  output logic             program_write_block_o,
  output logic             two_speed_startup_o,
  output logic [2:0]       startup_clock_o,
  output logic [2:0]       reset_clock_select_o,
  output logic             pulse_width_key_req_o,
  output logic             clock_switch_en_o,
  output logic             fail_safe_en_o,
  output logic             pin_remap_once_o,
  output logic             clock_out_en_o,
  output logic [1:0]       primary_osc_mode_o,
  output logic             primary_osc_en_o,
  output logic             watchdog_run_o,
  output logic             slow_internal_rc_run_o,
  output logic             watchdog_windowed_o,
  output logic [7:0]       watchdog_prescale_div_o,
  output logic [15:0]      watchdog_postscale_div_o,
  output logic [3:0]       watchdog_window_eighths_o,
  output logic             first_i2c_default_pins_o,
  output logic             second_i2c_default_pins_o,
  output logic             boundary_scan_on_o,
  output logic [1:0]       debug_pair_o,
  output logic             debug_channel_bad_o
);

  ////////////////////////////////////////////////////////////////////////
  // loading of configuration words

  logic        ld_vld;
  logic [2:0]  ld_idx;
  logic [15:0] ld_word;
  logic        ld_done;
  logic        start_q;
  logic [15:0] word_q [6];

  // kicks off once after reset release
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      start_q <= 1'b1;
    end else begin
      start_q <= 1'b0;
    end
  end

  cfgdec_nv_reader u_reader (
    .mclk_i     (mclk_i),
    .reset_i    (reset_i),
    .start_i    (start_q),
    .nv_addr_o  (nv_addr_o),
    .nv_rd_o    (nv_rd_o),
    .nv_data_i  (nv_data_i),
    .word_vld_o (ld_vld),
    .word_idx_o (ld_idx),
    .word_o     (ld_word),
    .done_o     (ld_done)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_word
      localparam logic [15:0] MASK = (gi == 0) ? `CFGDEC_MASK_SEC    :
                                     (gi == 1) ? `CFGDEC_MASK_OSCSEL :
                                     (gi == 2) ? `CFGDEC_MASK_OSC    :
                                     (gi == 3) ? `CFGDEC_MASK_WDT    :
                                     (gi == 4) ? `CFGDEC_MASK_POR    :
                                                 `CFGDEC_MASK_DEBUG;
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          word_q[gi] <= 16'hFFFF;
        // the last word arrives together with done, so done must not gate it
        end else if (ld_vld && ld_idx == 3'(gi)) begin
          word_q[gi] <= ld_word | ~MASK;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // field extraction

  logic       f_rd_guard;
  logic       f_wr_guard;
  logic       f_two_speed;
  logic       f_pwmlk;
  logic [2:0] f_clk_sel;
  logic [1:0] f_sw_mode;
  logic       f_iol1;
  logic       f_oscio;
  logic [1:0] f_posc_mode;
  logic       f_wd_force;
  logic       f_win_off;
  logic       f_wd_pre;
  logic [3:0] f_wd_post;
  logic [1:0] f_win_size;
  logic       f_i2c1;
  logic       f_i2c2;
  logic       f_scan_on;
  logic [1:0] f_dbg_chan;

  assign f_rd_guard  = word_q[0][`CFGDEC_RDGUARD_BIT];
  assign f_wr_guard  = word_q[0][`CFGDEC_WRGUARD_BIT];
  assign f_two_speed = word_q[1][`CFGDEC_TWOSPD_BIT];
  assign f_pwmlk     = word_q[1][`CFGDEC_PWMLK_BIT];
  assign f_clk_sel   = word_q[1][`CFGDEC_CLKSEL_LSB +: 3];
  assign f_sw_mode   = word_q[2][`CFGDEC_SWMODE_LSB +: 2];
  assign f_iol1      = word_q[2][`CFGDEC_IOL1_BIT];
  assign f_oscio     = word_q[2][`CFGDEC_OSCIO_BIT];
  assign f_posc_mode = word_q[2][`CFGDEC_PMODE_LSB +: 2];
  assign f_wd_force  = word_q[3][`CFGDEC_WDFORCE_BIT];
  assign f_win_off   = word_q[3][`CFGDEC_WINOFF_BIT];
  assign f_wd_pre    = word_q[3][`CFGDEC_WDPRE_BIT];
  assign f_wd_post   = word_q[3][`CFGDEC_WDPOST_LSB +: 4];
  assign f_win_size  = word_q[4][`CFGDEC_WDWIN_LSB +: 2];
  assign f_i2c2      = word_q[4][`CFGDEC_I2C2_BIT];
  assign f_i2c1      = word_q[4][`CFGDEC_I2C1_BIT];
  assign f_scan_on   = word_q[5][`CFGDEC_SCAN_BIT];
  assign f_dbg_chan  = word_q[5][`CFGDEC_DBGCH_LSB +: 2];

  logic soft_on_s1_q;
  logic soft_on_s2_q;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      soft_on_s1_q <= 1'b0;
      soft_on_s2_q <= 1'b0;
    end else begin
      soft_on_s1_q <= watchdog_soft_on_i;
      soft_on_s2_q <= soft_on_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded outputs, all registered

  logic crystal_mode;
  assign crystal_mode = (f_posc_mode == cfgdec_pkg::CFGDEC_POSC_XT) ||
                        (f_posc_mode == cfgdec_pkg::CFGDEC_POSC_HS);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_valid_o           <= 1'b0;
      program_read_block_o  <= 1'b1;
      program_write_block_o <= 1'b1;
      two_speed_startup_o   <= 1'b0;
      startup_clock_o       <= 3'h0;
      reset_clock_select_o  <= 3'h0;
      pulse_width_key_req_o <= 1'b1;
      clock_switch_en_o     <= 1'b0;
      fail_safe_en_o        <= 1'b0;
      pin_remap_once_o      <= 1'b1;
      clock_out_en_o        <= 1'b0;
      primary_osc_mode_o    <= 2'h3;
      primary_osc_en_o      <= 1'b0;
    end else begin
      // valid only once the last word has reached the decoders,
      // so every decoded output is settled when software sees it
      cfg_valid_o           <= ld_done && !ld_vld;
      program_read_block_o  <= !f_rd_guard;
      program_write_block_o <= !f_wr_guard;
      two_speed_startup_o   <= f_two_speed;
      startup_clock_o       <= f_two_speed ? 3'(cfgdec_pkg::CFGDEC_SRC_FAST) : f_clk_sel;
      reset_clock_select_o  <= f_clk_sel;
      pulse_width_key_req_o <= f_pwmlk;
      clock_switch_en_o     <= !f_sw_mode[1];
      fail_safe_en_o        <= f_sw_mode == 2'b00;
      pin_remap_once_o      <= f_iol1;
      clock_out_en_o        <= f_oscio && !crystal_mode;
      primary_osc_mode_o    <= f_posc_mode;
      primary_osc_en_o      <= f_posc_mode != cfgdec_pkg::CFGDEC_POSC_OFF;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      watchdog_run_o            <= 1'b0;
      slow_internal_rc_run_o    <= 1'b0;
      watchdog_windowed_o       <= 1'b0;
      watchdog_prescale_div_o   <= 8'd128;
      watchdog_postscale_div_o  <= 16'h0000;
      watchdog_window_eighths_o <= 4'd2;
      first_i2c_default_pins_o  <= 1'b1;
      second_i2c_default_pins_o <= 1'b1;
      boundary_scan_on_o        <= 1'b0;
      debug_pair_o              <= 2'h0;
      debug_channel_bad_o       <= 1'b0;
    end else begin
      watchdog_run_o            <= ld_done && (f_wd_force || soft_on_s2_q);
      slow_internal_rc_run_o    <= ld_done && (f_wd_force || soft_on_s2_q);
      watchdog_windowed_o       <= !f_win_off;
      watchdog_prescale_div_o   <= f_wd_pre ? 8'd128 : 8'd32;
      watchdog_postscale_div_o  <= 16'h0001 << f_wd_post;
      unique case (f_win_size)
        2'b11: watchdog_window_eighths_o <= 4'd2;
        2'b10: watchdog_window_eighths_o <= 4'd3;
        2'b01: watchdog_window_eighths_o <= 4'd4;
        2'b00: watchdog_window_eighths_o <= 4'd6;
      endcase
      first_i2c_default_pins_o  <= f_i2c1;
      second_i2c_default_pins_o <= f_i2c2;
      boundary_scan_on_o        <= f_scan_on;
      // 11 first, 10 second, 01 third
      debug_pair_o              <= 2'd3 - f_dbg_chan;
      debug_channel_bad_o       <= f_dbg_chan == 2'b00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave, zero wait states

  logic        rd_take;
  logic [31:0] rd_mux;

  // decode on the address phase so read data leaves a flop and
  // stands for the whole data phase with no wait state
  assign rd_take = hready && hsel && htrans[1] && !hwrite;

  // writes accepted with OKAY but change nothing
  always_comb begin
    unique case (haddr[11:0])
      `CFGDEC_OFS_IDENT:    rd_mux = {8'h00, DEVICE_ID};
      `CFGDEC_OFS_SECURITY: rd_mux = {16'h0000, word_q[0]};
      `CFGDEC_OFS_OSCSEL:   rd_mux = {16'h0000, word_q[1]};
      `CFGDEC_OFS_OSC:      rd_mux = {16'h0000, word_q[2]};
      `CFGDEC_OFS_WDT:      rd_mux = {16'h0000, word_q[3]};
      `CFGDEC_OFS_POR:      rd_mux = {16'h0000, word_q[4]};
      `CFGDEC_OFS_DEBUG:    rd_mux = {16'h0000, word_q[5]};
      `CFGDEC_OFS_DECODED:  rd_mux = {24'h000000, watchdog_run_o, clock_out_en_o,
                                      fail_safe_en_o, clock_switch_en_o,
                                      pulse_width_key_req_o, two_speed_startup_o,
                                      program_write_block_o, program_read_block_o};
      `CFGDEC_OFS_STATUS:   rd_mux = {30'h00000000, debug_channel_bad_o, cfg_valid_o};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // read data for the coming data phase; held otherwise
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= rd_mux;
    end
  end

endmodule // cfgdec_top

// ### verif/cfgdec_checker.sv
`timescale 1ns/10ps
`include "cfgdec_consts.svh"

module cfgdec_checker #(
  parameter logic [23:0] DEVICE_ID = 24'h00A5A5
) (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        nv_rd_o,
  input wire logic        watchdog_soft_on_i,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        cfg_valid_o,
  input wire logic        program_read_block_o,
  input wire logic        two_speed_startup_o,
  input wire logic [2:0]  startup_clock_o,
  input wire logic [2:0]  reset_clock_select_o,
  input wire logic        clock_switch_en_o,
  input wire logic        fail_safe_en_o,
  input wire logic        clock_out_en_o,
  input wire logic [1:0]  primary_osc_mode_o,
  input wire logic        primary_osc_en_o,
  input wire logic        watchdog_run_o,
  input wire logic        slow_internal_rc_run_o,
  input wire logic [7:0]  watchdog_prescale_div_o,
  input wire logic [15:0] watchdog_postscale_div_o,
  input wire logic [1:0]  debug_pair_o,
  input wire logic        debug_channel_bad_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////
  a_load_bound: assert property ($fell(reset_i) |-> ##[1:40] cfg_valid_o)
    else $error("settings not loaded in time");
  a_settings_hold: assert property (cfg_valid_o && $past(cfg_valid_o) |->
    $stable(reset_clock_select_o) && $stable(program_read_block_o) && !nv_rd_o)
    else $error("settings changed after load");
  a_startup_clock: assert property (cfg_valid_o |->
    startup_clock_o == (two_speed_startup_o ? 3'h0 : reset_clock_select_o))
    else $error("startup clock wrong");
  a_monitor_needs_switch: assert property (fail_safe_en_o |-> clock_switch_en_o)
    else $error("monitor without switching");
  a_crystal_no_clkout: assert property (cfg_valid_o &&
    primary_osc_mode_o inside {2'h1, 2'h2} |-> !clock_out_en_o)
    else $error("clock out in crystal mode");
  a_posc_enable: assert property (cfg_valid_o |->
    primary_osc_en_o == (primary_osc_mode_o != 2'h3))
    else $error("primary enable wrong");
  a_soft_wdt_on: assert property ((cfg_valid_o && watchdog_soft_on_i) [*5] |->
    watchdog_run_o && slow_internal_rc_run_o)
    else $error("watchdog not running");
  a_wdt_rc_pair: assert property (watchdog_run_o == slow_internal_rc_run_o)
    else $error("watchdog and slow rc differ");
  a_prescale_vals: assert property (cfg_valid_o |->
    watchdog_prescale_div_o inside {8'h80, 8'h20})
    else $error("prescale value illegal");
  a_postscale_onehot: assert property (cfg_valid_o |-> $onehot(watchdog_postscale_div_o))
    else $error("postscale not a power of two");
  a_debug_pair: assert property (cfg_valid_o && !debug_channel_bad_o |->
    debug_pair_o != 2'h3)
    else $error("debug pair illegal");
  a_ident_read: assert property (hsel && hready && htrans[1] && !hwrite &&
    haddr[11:0] == `CFGDEC_OFS_IDENT |=> hrdata[23:0] == DEVICE_ID)
    else $error("identifier read wrong");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay");

  c_loaded: cover property ($rose(cfg_valid_o));
  c_two_speed: cover property (cfg_valid_o && two_speed_startup_o);
  c_fail_safe: cover property (cfg_valid_o && fail_safe_en_o);
  c_debug_bad: cover property (cfg_valid_o && debug_channel_bad_o);
endmodule // cfgdec_checker

bind cfgdec_top cfgdec_checker #(.DEVICE_ID(DEVICE_ID)) chk_u (
  .mclk_i(mclk_i), .reset_i(reset_i), .nv_rd_o(nv_rd_o),
  .watchdog_soft_on_i(watchdog_soft_on_i), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .cfg_valid_o(cfg_valid_o), .program_read_block_o(program_read_block_o),
  .two_speed_startup_o(two_speed_startup_o), .startup_clock_o(startup_clock_o),
  .reset_clock_select_o(reset_clock_select_o), .clock_switch_en_o(clock_switch_en_o),
  .fail_safe_en_o(fail_safe_en_o), .clock_out_en_o(clock_out_en_o),
  .primary_osc_mode_o(primary_osc_mode_o), .primary_osc_en_o(primary_osc_en_o),
  .watchdog_run_o(watchdog_run_o), .slow_internal_rc_run_o(slow_internal_rc_run_o),
  .watchdog_prescale_div_o(watchdog_prescale_div_o),
  .watchdog_postscale_div_o(watchdog_postscale_div_o),
  .debug_pair_o(debug_pair_o), .debug_channel_bad_o(debug_channel_bad_o));

// ### verif/config_fuse_decoder_bench.sv
`timescale 1ns/10ps
`include "cfgdec_consts.svh"

module config_fuse_decoder_bench;
  // arbitrary identification value
  localparam logic [23:0] ID = 24'h3C5A12;

  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] nv_data_i = 16'h0000;
  logic        soft_q = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, nv_rd_o, cfg_valid_o, rd_blk, wr_blk, two_spd, key_req;
  logic        sw_en, fs_en, remap1, clko_en, posc_en, wdt_run, slow_run, windowed;
  logic        i2c1_def, i2c2_def, bscan, dbg_bad;
  logic [2:0]  nv_addr_o, start_clk, clk_sel;
  logic [1:0]  posc_mode, dbg_pair;
  logic [7:0]  pre_div;
  logic [15:0] post_div;
  logic [3:0]  win8;
  logic [15:0] mem [6];
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;

  cfgdec_top #(.DEVICE_ID(ID)) dut_u (
    .mclk_i(mclk_i), .reset_i(reset_i), .nv_addr_o(nv_addr_o), .nv_rd_o(nv_rd_o),
    .nv_data_i(nv_data_i), .watchdog_soft_on_i(soft_q), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cfg_valid_o(cfg_valid_o),
    .program_read_block_o(rd_blk), .program_write_block_o(wr_blk),
    .two_speed_startup_o(two_spd), .startup_clock_o(start_clk),
    .reset_clock_select_o(clk_sel), .pulse_width_key_req_o(key_req),
    .clock_switch_en_o(sw_en), .fail_safe_en_o(fs_en), .pin_remap_once_o(remap1),
    .clock_out_en_o(clko_en), .primary_osc_mode_o(posc_mode), .primary_osc_en_o(posc_en),
    .watchdog_run_o(wdt_run), .slow_internal_rc_run_o(slow_run),
    .watchdog_windowed_o(windowed), .watchdog_prescale_div_o(pre_div),
    .watchdog_postscale_div_o(post_div), .watchdog_window_eighths_o(win8),
    .first_i2c_default_pins_o(i2c1_def), .second_i2c_default_pins_o(i2c2_def),
    .boundary_scan_on_o(bscan), .debug_pair_o(dbg_pair), .debug_channel_bad_o(dbg_bad));

  ////////////////////////////////////////////////////////////
  always #2.5 mclk_i = ~mclk_i;

  // storage model: word appears the edge after the strobe and holds
  always @(posedge mclk_i) begin
    if (nv_rd_o) begin
      nv_data_i <= mem[nv_addr_o];
    end
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // single transfer; the bench never assumes a wait count
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic load(input logic [3:0] c);
    int k;
    mem[0] = {14'h0000, c[1:0]};
    mem[1] = {8'h00, c[0], c[1], 3'h0, c[2:0]};
    mem[2] = {8'h00, c[3:2], c[0], 2'h0, c[2], c[1:0]};
    mem[3] = {8'h00, c[1], c[2], 1'b0, c[3], c};
    mem[4] = {8'h00, c[1:0], c[2], c[3], 4'h0};
    mem[5] = {10'h000, c[0], 3'h0, c[1:0]};
    reset_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    k = 0;
    while (cfg_valid_o !== 1'b1 && k < 100) begin
      @(posedge mclk_i);
      k++;
    end
    cmp(cfg_valid_o, 1, "loaded");
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_decode(input logic [3:0] c);
    logic [3:0] e8;
    e8 = (c[1:0] == 2'h3) ? 4'h2 : (c[1:0] == 2'h2) ? 4'h3 : (c[1:0] == 2'h1) ? 4'h4 : 4'h6;
    load(c);
    cmp(rd_blk, !c[1], "read guard");
    cmp(wr_blk, !c[0], "write guard");
    cmp(two_spd, c[0], "two speed");
    cmp(start_clk, c[0] ? 3'h0 : c[2:0], "startup clock");
    cmp(key_req, c[1], "pwm key");
    cmp(clk_sel, c[2:0], "clock select");
    cmp({sw_en, fs_en}, {!c[3], c[3:2] == 2'h0}, "switch mode");
    cmp(remap1, c[0], "remap once");
    cmp(clko_en, c[2] && !(c[1:0] inside {2'h1, 2'h2}), "clock out");
    cmp({posc_mode, posc_en}, {c[1:0], c[1:0] != 2'h3}, "primary mode");
    cmp(windowed, !c[2], "window mode");
    cmp(pre_div, c[3] ? 8'h80 : 8'h20, "prescale");
    cmp(post_div, 16'h0001 << c, "postscale");
    cmp(win8, e8, "window size");
    cmp({i2c1_def, i2c2_def}, {c[3], c[2]}, "i2c route");
    cmp(bscan, c[0], "scan enable");
    cmp(dbg_bad, c[1:0] == 2'h0, "debug reserved");
    if (c[1:0] != 2'h0) cmp(dbg_pair, 2'h3 - c[1:0], "debug pair");
    soft_q <= 1'b0;
    repeat (6) @(posedge mclk_i);
    cmp({wdt_run, slow_run}, {2{c[1]}}, "watchdog soft off");
    soft_q <= 1'b1;
    repeat (6) @(posedge mclk_i);
    cmp({wdt_run, slow_run}, 2'h3, "watchdog soft on");
    soft_q <= 1'b0;
    mem[1] = ~mem[1];
    repeat (20) @(posedge mclk_i);
    cmp(clk_sel, c[2:0], "held after load");
    $display("decode %h done", c);
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic [15:0] msk [6];
    msk = '{`CFGDEC_MASK_SEC, `CFGDEC_MASK_OSCSEL, `CFGDEC_MASK_OSC, `CFGDEC_MASK_WDT,
            `CFGDEC_MASK_POR, `CFGDEC_MASK_DEBUG};
    load(4'h6);
    ahb(1'b0, `CFGDEC_OFS_IDENT, 32'h0, rd);
    cmp(rd, {8'h00, ID}, "identifier");
    ahb(1'b1, `CFGDEC_OFS_IDENT, 32'hFFFFFFFF, rd);
    ahb(1'b0, `CFGDEC_OFS_IDENT, 32'h0, rd);
    cmp(rd, {8'h00, ID}, "identifier after write");
    for (int k = 0; k < 6; k++) begin
      ahb(1'b0, 32'h4 * (k + 1), 32'h0, rd);
      cmp(rd, {16'h0000, mem[k] | ~msk[k]}, "config word");
    end
    // code 6: watchdog forced, switching, key, write blocked
    ahb(1'b0, `CFGDEC_OFS_DECODED, 32'h0, rd);
    cmp(rd, 32'h0000009A, "decoded summary");
    ahb(1'b0, `CFGDEC_OFS_STATUS, 32'h0, rd);
    cmp(rd, 32'h00000001, "status");
    ahb(1'b0, 32'h40, 32'h0, rd);
    cmp(rd, 32'h0, "unmapped");
    cmp(hresp, 1'b0, "okay response");
    $display("registers done");
  endtask

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    for (int c = 0; c < 16; c++) begin
      t_decode(c[3:0]);
    end
    t_regs();
    end_of_test();
  end
endmodule // config_fuse_decoder_bench
